// *** tb_thermocouple_channel_processing.sv ***
// self-checking bench of the channel processor
// assumes tcp_channels answers APB with zero wait states and starts a scan on the first SCAN_DIV tick after the last scan ends
`timescale 1ns/1ns
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin mismatches++; $display("[FAIL] %0t got %h exp %h", $time, g, x); end end
module tb_thermocouple_channel_processing;
	// -------------------------------------------------
	// signals
	// -------------------------------------------------
	localparam int DIV = 8;
	localparam int SETTLE = 2 * (8 * 6 + 1 + DIV);
	typedef struct {int ch; logic [31:0] cfg; logic [31:0] cjof;
		logic signed [15:0] raw; logic signed [15:0] exp; logic err;} tcp_row_t;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, remote_en = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic pready, pslverr, e;
	logic signed [15:0] mv_set [8] = '{default: 16'h0000};
	logic signed [15:0] raw_mv [8], thermistor_temp, host_analog_word;
	tcp_pkg::tcp_alarm_t alarm_msg, last_alarm;
	int mismatches = 0, total_checks = 0, cycles = 0, n_alarm = 0;
	tcp_row_t rows [8];
	logic [31:0] rst_w [3];
	always #5 pclk = ~pclk;
	tcp_channels #(.SCAN_DIV(DIV)) u_tcp_channels (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .raw_mv(raw_mv), .thermistor_temp(thermistor_temp),
		.host_analog_word(host_analog_word), .alarm_msg(alarm_msg));
	tcp_field_model u_tcp_field_model (.pclk(pclk), .presetn(presetn), .mv_set(mv_set),
		.local_set(16'h03E8), .remote_set(16'h07D0), .remote_en(remote_en), .raw_mv(raw_mv),
		.thermistor_temp(thermistor_temp), .host_analog_word(host_analog_word));
	// -------------------------------------------------
	// helpers
	// -------------------------------------------------
	function automatic logic [31:0] cfg(input logic [1:0] u, input logic [3:0] t,
		input logic [2:0] s, input logic [1:0] c);
		return {20'h00000, c, s, t, u, 1'b1};
	endfunction
	function automatic logic [7:0] adr(input int ch, input logic [1:0] w);
		return {1'b0, ch[2:0], w, 2'b00};
	endfunction
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		forever begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// -------------------------------------------------
	// monitor and timeout
	// -------------------------------------------------
	always @(posedge pclk) begin
		cycles++;
		if (alarm_msg.valid === 1'b1) begin
			n_alarm++;
			last_alarm = alarm_msg;
		end
		if (cycles == 6000) begin
			mismatches++;
			close_out();
		end
	end
	// -------------------------------------------------
	// sequence
	// -------------------------------------------------
	initial begin
		rows = '{'{0, 32'h0, 32'h0, 16'h04D2, 16'h0000, 1'b0},
			'{1, cfg(2'h0, 4'h0, 3'h6, 2'h3), 32'h0, 16'hFE0C, 16'hFE0C, 1'b0},
			'{2, cfg(2'h1, 4'h0, 3'h6, 2'h3), 32'h0032_0000, 16'h03E8, 16'h041A, 1'b0},
			'{3, cfg(2'h0, 4'h0, 3'h1, 2'h3), 32'h0, 16'h07D0, 16'h07A1, 1'b1},
			'{4, cfg(2'h1, 4'h1, 3'h6, 2'h3), 32'h0, 16'h0100, 16'h01D9, 1'b0},
			'{5, cfg(2'h2, 4'h1, 3'h6, 2'h3), 32'h0, 16'h0100, 16'h0494, 1'b0},
			'{6, cfg(2'h1, 4'h1, 3'h6, 2'h0), 32'h0, 16'h0100, 16'h023D, 1'b0},
			'{7, cfg(2'h1, 4'h1, 3'h6, 2'h2), 32'h64, 16'h0100, 16'h0292, 1'b0}};
		rst_w = '{tcp_pkg::CFG_RST, tcp_pkg::LIM_RST, tcp_pkg::CJOF_RST};
		settle(20);
		presetn <= 1'b1;
		for (int w = 0; w < 3; w++) begin
			apb(1'b0, adr(5, w[1:0]), 32'h0);
			`CHK(q, rst_w[w])
		end
		apb(1'b0, 8'h80, 32'h0);
		`CHK({e, q}, {1'b1, 32'h0})
		apb(1'b1, 8'h06, 32'h0);
		`CHK(e, 1'b1)
		// one channel per row, all configured before a single wait
		foreach (rows[i]) begin
			mv_set[rows[i].ch] <= rows[i].raw;
			apb(1'b1, adr(rows[i].ch, tcp_pkg::W_CFG), rows[i].cfg);
			apb(1'b1, adr(rows[i].ch, tcp_pkg::W_CJOF), rows[i].cjof);
		end
		settle(SETTLE);
		foreach (rows[i]) begin
			apb(1'b0, adr(rows[i].ch, tcp_pkg::W_RES), 32'h0);
			`CHK(q[15:0], rows[i].exp)
			if (i > 0 && i < 4) `CHK(q[18], rows[i].err)
		end
		// unused span code: reading forced to zero and flagged
		apb(1'b1, adr(3, tcp_pkg::W_CFG), cfg(2'h0, 4'h0, 3'h0, 2'h3));
		settle(SETTLE);
		apb(1'b0, adr(3, tcp_pkg::W_RES), 32'h0);
		`CHK(q[18:0], 19'h40000)
		remote_en <= 1'b1;
		apb(1'b1, adr(7, tcp_pkg::W_CFG), cfg(2'h1, 4'h1, 3'h6, 2'h1));
		settle(SETTLE);
		apb(1'b0, adr(7, tcp_pkg::W_RES), 32'h0);
		`CHK(q[15:0], 16'h02A1)
		// high limit reached, held, left and reached again
		apb(1'b1, adr(1, tcp_pkg::W_LIM), 32'h01F4_8001);
		settle(SETTLE);
		n_alarm = 0;
		mv_set[1] <= 16'h03E8;
		settle(2 * SETTLE);
		`CHK(n_alarm, 1)
		`CHK({last_alarm.high, last_alarm.chan}, 4'h9)
		`CHK(last_alarm.value, 16'h03E8)
		apb(1'b0, adr(1, tcp_pkg::W_RES), 32'h0);
		`CHK(q[17:0], 18'h203E8)
		mv_set[1] <= 16'h0000;
		settle(SETTLE);
		mv_set[1] <= 16'h03E8;
		settle(SETTLE);
		`CHK(n_alarm, 2)
		apb(1'b1, adr(1, tcp_pkg::W_LIM), 32'h01F4_FCE0);
		mv_set[1] <= 16'hFC18;
		settle(SETTLE);
		`CHK(n_alarm, 3)
		`CHK({last_alarm.high, last_alarm.chan, last_alarm.value}, 20'h1FC18)
		// reset in mid-run: configuration back to defaults, every channel active again
		presetn <= 1'b0;
		settle(2);
		presetn <= 1'b1;
		apb(1'b0, adr(7, tcp_pkg::W_CFG), 32'h0);
		`CHK(q, tcp_pkg::CFG_RST)
		settle(SETTLE);
		apb(1'b0, adr(0, tcp_pkg::W_RES), 32'h0);
		`CHK(q[18:0], 19'h004D2)
		`CHK(n_alarm, 3)
		close_out();
	end
endmodule

// *** tcp_channels.sv ***
// scanner, shared datapath and APB register file of the channel processor
// assumes raw readings and thermistor value are synchronous to pclk
`timescale 1ns/1ns
module tcp_channels #(
	parameter int CH_N = tcp_pkg::CH_N,
	parameter int SCAN_DIV = tcp_pkg::SCAN_DIV
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// measurements
	input wire logic signed [15:0] raw_mv [CH_N],
	input wire logic signed [15:0] thermistor_temp,
	input wire logic signed [15:0] host_analog_word,
	// alarm messages
	output tcp_pkg::tcp_alarm_t alarm_msg
);
	// -------------------------------------------------
	// helpers
	// -------------------------------------------------
	function automatic logic signed [31:0] sx(input logic [15:0] v);
		sx = {{16{v[15]}}, v};
	endfunction
	function automatic logic signed [31:0] sat(input logic signed [31:0] v);
		if (v > tcp_pkg::VAL_MAX) begin
			sat = tcp_pkg::VAL_MAX;
		end else if (v < -tcp_pkg::VAL_MAX) begin
			sat = -tcp_pkg::VAL_MAX;
		end else begin
			sat = v;
		end
	endfunction

	logic [31:0] cfg_r [CH_N];
	logic [31:0] lim_r [CH_N];
	logic [31:0] cjof_r [CH_N];
	logic [15:0] res_val_r [CH_N];
	logic res_lo_r [CH_N];
	logic res_hi_r [CH_N];
	logic res_err_r [CH_N];
	logic lo_arm_r [CH_N];
	logic hi_arm_r [CH_N];
	tcp_pkg::tcp_state_t state_r;
	logic [2:0] ch_r;
	logic [15:0] div_r;
	logic tick;
	logic signed [31:0] mv_r;
	logic signed [31:0] temp_r;
	logic signed [31:0] val_r;
	logic err_r;

	// -------------------------------------------------
	// apb decode
	// -------------------------------------------------
	logic [2:0] a_ch;
	logic [1:0] a_w;
	logic a_ok;
	logic wr_en;
	assign a_ch = paddr[6:4];
	assign a_w = paddr[3:2];
	assign a_ok = (paddr < tcp_pkg::MAP_END) && (paddr[1:0] == 2'b00);
	assign wr_en = psel && penable && pwrite && a_ok;
	// zero wait states: read data is captured in the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel && penable && !a_ok;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			if (!a_ok) begin
				prdata <= 32'h0000_0000;
			end else if (a_w == tcp_pkg::W_CFG) begin
				prdata <= cfg_r[a_ch];
			end else if (a_w == tcp_pkg::W_LIM) begin
				prdata <= lim_r[a_ch];
			end else if (a_w == tcp_pkg::W_CJOF) begin
				prdata <= cjof_r[a_ch];
			end else begin
				prdata <= {13'h0000, res_err_r[a_ch], res_hi_r[a_ch], res_lo_r[a_ch],
					res_val_r[a_ch]};
			end
		end
	end

	// -------------------------------------------------
	// per-channel configuration
	// -------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < CH_N; g++) begin : g_cfg
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cfg_r[g] <= tcp_pkg::CFG_RST;
					lim_r[g] <= tcp_pkg::LIM_RST;
					cjof_r[g] <= tcp_pkg::CJOF_RST;
				end else if (wr_en && a_ch == 3'(g)) begin
					if (a_w == tcp_pkg::W_CFG) begin
						cfg_r[g] <= {20'h00000, pwdata[11:0]};
					end else if (a_w == tcp_pkg::W_LIM) begin
						lim_r[g] <= pwdata;
					end else if (a_w == tcp_pkg::W_CJOF) begin
						cjof_r[g] <= pwdata;
					end
				end
			end
		end
	endgenerate

	// -------------------------------------------------
	// current channel fields
	// -------------------------------------------------
	logic act_c;
	logic [1:0] unit_c;
	logic [3:0] type_c;
	logic [2:0] span_c;
	logic [1:0] cj_c;
	logic signed [31:0] lo_c;
	logic signed [31:0] hi_c;
	logic signed [31:0] span_mv;
	logic signed [31:0] cj_add;
	logic lo_hit;
	logic hi_hit;
	logic [2:0] ch_nxt;
	assign act_c = cfg_r[ch_r][tcp_pkg::ACT_BIT];
	assign unit_c = cfg_r[ch_r][tcp_pkg::UNIT_LSB +: 2];
	assign type_c = cfg_r[ch_r][tcp_pkg::TYPE_LSB +: 4];
	assign span_c = cfg_r[ch_r][tcp_pkg::SPAN_LSB +: 3];
	assign cj_c = cfg_r[ch_r][tcp_pkg::CJ_LSB +: 2];
	assign lo_c = sx(lim_r[ch_r][15:0]);
	assign hi_c = sx(lim_r[ch_r][31:16]);
	assign span_mv = tcp_pkg::SPAN_TBL[span_c];
	// host word is consulted in remote mode only
	assign cj_add = (cj_c == tcp_pkg::CJ_LOCAL) ? sx(thermistor_temp) :
		(cj_c == tcp_pkg::CJ_REMOTE) ? sx(host_analog_word) :
		32'sh0000_0000;
	// limits meet the value already in reporting units
	assign lo_hit = val_r <= lo_c;
	assign hi_hit = val_r >= hi_c;
	assign ch_nxt = ch_r + 3'd1;

	// -------------------------------------------------
	// scan pacing
	// -------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 16'h0000;
		end else if (div_r == 16'(SCAN_DIV - 1)) begin
			div_r <= 16'h0000;
		end else begin
			div_r <= div_r + 16'h0001;
		end
	end
	assign tick = div_r == 16'(SCAN_DIV - 1);

	// -------------------------------------------------
	// scan sequencer
	// -------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= tcp_pkg::ST_IDLE;
			ch_r <= 3'h0;
		end else begin
			case (state_r)
				tcp_pkg::ST_IDLE: begin
					if (tick) begin
						ch_r <= 3'h0;
						// inactive channels skip straight to the update
						state_r <= cfg_r[0][tcp_pkg::ACT_BIT] ? tcp_pkg::ST_COMP :
							tcp_pkg::ST_UPD;
					end
				end
				tcp_pkg::ST_COMP: state_r <= tcp_pkg::ST_LIN;
				tcp_pkg::ST_LIN: state_r <= tcp_pkg::ST_UNIT;
				tcp_pkg::ST_UNIT: state_r <= tcp_pkg::ST_OFFS;
				tcp_pkg::ST_OFFS: state_r <= tcp_pkg::ST_ALARM;
				tcp_pkg::ST_ALARM: state_r <= tcp_pkg::ST_UPD;
				tcp_pkg::ST_UPD: begin
					if (ch_r == 3'(CH_N - 1)) begin
						state_r <= tcp_pkg::ST_IDLE;
					end else begin
						ch_r <= ch_nxt;
						state_r <= cfg_r[ch_nxt][tcp_pkg::ACT_BIT] ? tcp_pkg::ST_COMP :
							tcp_pkg::ST_UPD;
					end
				end
				default: state_r <= tcp_pkg::ST_IDLE;
			endcase
		end
	end

	// -------------------------------------------------
	// datapath
	// -------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mv_r <= 32'sh0000_0000;
			temp_r <= 32'sh0000_0000;
			val_r <= 32'sh0000_0000;
			err_r <= 1'b0;
		end else begin
			case (state_r)
				tcp_pkg::ST_COMP: begin
					if (type_c == tcp_pkg::TYPE_NONE) begin
						// span clamps a raw reading and marks it out of range
						err_r <= (span_mv == 0) || (sx(raw_mv[ch_r]) > span_mv) ||
							(sx(raw_mv[ch_r]) < -span_mv);
						mv_r <= (sx(raw_mv[ch_r]) > span_mv) ? span_mv :
							(sx(raw_mv[ch_r]) < -span_mv) ? -span_mv :
							sx(raw_mv[ch_r]);
					end else begin
						err_r <= 1'b0;
						mv_r <= sx(raw_mv[ch_r]) + ((cj_c == tcp_pkg::CJ_FIXED) ?
							sx(cjof_r[ch_r][15:0]) : 32'sh0000_0000);
					end
				end
				tcp_pkg::ST_LIN: begin
					if (type_c == tcp_pkg::TYPE_NONE) begin
						temp_r <= mv_r;
					end else begin
						temp_r <= ((mv_r * tcp_pkg::TC_GAIN[type_c]) >>> 8) + cj_add;
					end
				end
				tcp_pkg::ST_UNIT: begin
					if (type_c == tcp_pkg::TYPE_NONE || unit_c == tcp_pkg::UNIT_MV) begin
						val_r <= mv_r;
					end else if (unit_c == tcp_pkg::UNIT_C) begin
						val_r <= temp_r / 10;
					end else begin
						val_r <= (temp_r * 9) / 50 + 320;
					end
				end
				tcp_pkg::ST_OFFS: val_r <= sat(val_r + sx(cjof_r[ch_r][31:16]));
				default: val_r <= val_r;
			endcase
		end
	end

	// -------------------------------------------------
	// alarms and results
	// -------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_msg <= '0;
			for (int i = 0; i < CH_N; i++) begin
				lo_arm_r[i] <= 1'b1;
				hi_arm_r[i] <= 1'b1;
			end
		end else begin
			alarm_msg.valid <= 1'b0;
			if (state_r == tcp_pkg::ST_ALARM) begin
				alarm_msg.chan <= ch_r;
				alarm_msg.value <= val_r[15:0];
				if (lo_hit && lo_arm_r[ch_r]) begin
					alarm_msg.valid <= 1'b1;
					alarm_msg.high <= 1'b0;
				end else if (hi_hit && hi_arm_r[ch_r]) begin
					alarm_msg.valid <= 1'b1;
					alarm_msg.high <= 1'b1;
				end
				// a message disarms; leaving the limit re-arms
				lo_arm_r[ch_r] <= !lo_hit;
				hi_arm_r[ch_r] <= !hi_hit || (lo_hit && lo_arm_r[ch_r]);
			end else if (state_r == tcp_pkg::ST_UPD && !act_c) begin
				lo_arm_r[ch_r] <= 1'b1;
				hi_arm_r[ch_r] <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < CH_N; i++) begin
				res_val_r[i] <= 16'h0000;
				res_lo_r[i] <= 1'b0;
				res_hi_r[i] <= 1'b0;
				res_err_r[i] <= 1'b0;
			end
		end else if (state_r == tcp_pkg::ST_UPD) begin
			res_val_r[ch_r] <= act_c ? val_r[15:0] : 16'h0000;
			res_lo_r[ch_r] <= act_c && lo_hit;
			res_hi_r[ch_r] <= act_c && hi_hit;
			res_err_r[ch_r] <= act_c && err_r;
		end
	end

	// -------------------------------------------------
	// checks
	// -------------------------------------------------
	chk_inactive_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r == tcp_pkg::ST_UPD && !act_c) |=> res_val_r[$past(ch_r)] == 16'h0000)
		else $error("inactive channel result not zero");
	chk_active_scan: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r == tcp_pkg::ST_IDLE && tick && cfg_r[0][0]) |=> state_r == tcp_pkg::ST_COMP)
		else $error("active channel not scanned");
	chk_stage_order: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == tcp_pkg::ST_COMP |=> state_r == tcp_pkg::ST_LIN ##1
		state_r == tcp_pkg::ST_UNIT ##1 state_r == tcp_pkg::ST_OFFS ##1
		state_r == tcp_pkg::ST_ALARM ##1 state_r == tcp_pkg::ST_UPD)
		else $error("processing stages out of order");
	chk_span_unused: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r == tcp_pkg::ST_COMP && type_c == 4'h0 && span_c == 3'h0) |=> err_r)
		else $error("unused span not flagged");
	chk_alarm_msg: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r == tcp_pkg::ST_ALARM && lo_hit && lo_arm_r[ch_r]) |=>
		alarm_msg.valid && !alarm_msg.high && alarm_msg.chan == $past(ch_r))
		else $error("low alarm message missing");
	chk_alarm_once: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r == tcp_pkg::ST_ALARM && !(lo_hit && lo_arm_r[ch_r]) &&
		!(hi_hit && hi_arm_r[ch_r])) |=> !alarm_msg.valid)
		else $error("repeated alarm message");
	chk_value_kept: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == tcp_pkg::ST_ALARM |=> state_r == tcp_pkg::ST_UPD && val_r == $past(val_r) ##1
		res_val_r[$past(ch_r, 2)] == $past(val_r[15:0], 2))
		else $error("alarm stage altered value or stalled");
	chk_alarm_high: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r == tcp_pkg::ST_ALARM && !lo_hit && hi_hit && hi_arm_r[ch_r]) |=>
		alarm_msg.valid && alarm_msg.high && alarm_msg.value == $past(val_r[15:0]))
		else $error("high alarm message missing");
	chk_alarm_norepeat: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r == tcp_pkg::ST_ALARM && hi_hit && !hi_arm_r[ch_r] && !lo_hit) |=>
		!alarm_msg.valid)
		else $error("high alarm repeated");
	chk_alarm_rearm: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r == tcp_pkg::ST_ALARM && !lo_hit) |=> lo_arm_r[$past(ch_r)])
		else $error("alarm not re-armed");
endmodule

// *** tcp_field_model.sv ***
// model of the field side: thermocouple inputs, local thermistor, host junction word
// assumes the bench sets the wanted levels; outputs move one pclk after a change
`timescale 1ns/1ns
module tcp_field_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// wanted levels
	input wire logic signed [15:0] mv_set [tcp_pkg::CH_N],
	input wire logic signed [15:0] local_set,
	input wire logic signed [15:0] remote_set,
	input wire logic remote_en,
	// towards the channel processor
	output logic signed [15:0] raw_mv [tcp_pkg::CH_N],
	output logic signed [15:0] thermistor_temp,
	output logic signed [15:0] host_analog_word
);
	// -------------------------------------------------
	// readings
	// -------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raw_mv <= '{default: 16'h0000};
			thermistor_temp <= 16'h0000;
			host_analog_word <= 16'h5A5A;
		end else begin
			raw_mv <= mv_set;
			thermistor_temp <= local_set;
			// an unmapped word is junk, so it toggles every cycle to expose misuse
			if (remote_en) begin
				host_analog_word <= remote_set;
			end else begin
				host_analog_word <= ~host_analog_word;
			end
		end
	end
endmodule

// *** tcp_pkg.sv ***
// constants, types and register map of the thermocouple channel processor
// assumes one 100 MHz clock and an APB master reaching the register file
package tcp_pkg;
	localparam int CH_N = 8;
	localparam int CLK_NS = 10;
	localparam int SCAN_NS = 1000;
	localparam int SCAN_DIV = (SCAN_NS + CLK_NS - 1) / CLK_NS;
	// -------------------------------------------------
	// register map: channel in paddr[6:4], word in paddr[3:2]
	// -------------------------------------------------
	localparam logic [7:0] MAP_END = 8'h80;
	localparam logic [1:0] W_CFG = 2'h0;
	localparam logic [1:0] W_LIM = 2'h1;
	localparam logic [1:0] W_CJOF = 2'h2;
	localparam logic [1:0] W_RES = 2'h3;
	localparam int ACT_BIT = 0;
	localparam int UNIT_LSB = 1;
	localparam int TYPE_LSB = 3;
	localparam int SPAN_LSB = 7;
	localparam int CJ_LSB = 10;
	localparam int RES_LO_BIT = 16;
	localparam int RES_HI_BIT = 17;
	localparam int RES_ERR_BIT = 18;
	localparam logic [31:0] CFG_RST = 32'h0000_0301;
	localparam logic [31:0] LIM_RST = 32'h7FFF_8001;
	localparam logic [31:0] CJOF_RST = 32'h0000_0000;
	localparam logic signed [31:0] VAL_MAX = 32'sh0000_7FFF;
	localparam logic [3:0] TYPE_NONE = 4'h0;
	// span in 0.01 mV per span code; codes 0 and 7 are unused
	localparam int SPAN_TBL [0:7] = '{0, 1953, 3900, 7813, 15625, 31250, 62500, 0};
	// straight-line fit, 0.01 degC per 0.01 mV scaled by 256; real curves live elsewhere
	localparam int TC_GAIN [0:15] = '{0, 4736, 6400, 4992, 3456, 24320, 21504, 33792,
		6912, 15360, 15360, 14848, 6400, 0, 0, 0};
	typedef enum logic [1:0] {
		UNIT_MV = 2'b00,
		UNIT_C = 2'b01,
		UNIT_F = 2'b10
	} tcp_unit_t;
	typedef enum logic [1:0] {
		CJ_LOCAL = 2'b00,
		CJ_REMOTE = 2'b01,
		CJ_FIXED = 2'b10,
		CJ_NONE = 2'b11
	} tcp_cj_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_COMP = 3'b001,
		ST_LIN = 3'b010,
		ST_UNIT = 3'b011,
		ST_OFFS = 3'b100,
		ST_ALARM = 3'b101,
		ST_UPD = 3'b110
	} tcp_state_t;
	typedef struct packed {
		logic valid;
		logic high;
		logic [2:0] chan;
		logic [15:0] value;
	} tcp_alarm_t;
endpackage
